// File: design/page_addr_pkg.sv
package page_addr_pkg;
  // register pointer values for the parametric register port
  localparam logic [3:0] PTR_FIFO = 4'h0;
  localparam logic [3:0] PTR_UTIL = 4'ha;
  localparam logic [3:0] PTR_COUNT_LO = 4'hb;
  localparam logic [3:0] PTR_COUNT_HI = 4'hc;
  localparam logic [3:0] PTR_ENABLE = 4'hd;
  localparam logic [3:0] PTR_ADDR_LO = 4'he;
  localparam logic [3:0] PTR_ADDR_HI = 4'hf;
  // field layout
  localparam int PAGE_BITS = 11;
  localparam int WIDTH_LSB = 12;
  localparam int BANK_LSB = 11;
  localparam int BANK_BITS = 4;
  // channel width codes
  localparam logic [3:0] WIDTH_X1 = 4'h0;
  localparam logic [3:0] WIDTH_X2 = 4'h1;
  localparam logic [3:0] WIDTH_X4 = 4'h2;
  localparam logic [3:0] WIDTH_X8 = 4'h4;
  localparam logic [3:0] WIDTH_X16 = 4'h8;
  // page sizes in bytes
  localparam logic [9:0] PAGE_BYTES_X1 = 10'h020;
  localparam logic [9:0] PAGE_BYTES_X2 = 10'h040;
  localparam logic [9:0] PAGE_BYTES_X4 = 10'h080;
  localparam logic [9:0] PAGE_BYTES_X8 = 10'h100;
  localparam logic [9:0] PAGE_BYTES_X16 = 10'h200;
  // reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic [15:0] CHAN_EN_RESET = 16'h0001;
  localparam logic [9:0] PAGE_BYTES_RESET = 10'h020;
  localparam logic [11:0] PAGES_LEFT_RESET = 12'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // last page of one bubble, the point where the bank select carries
  localparam logic [10:0] LAST_PAGE = 11'h7ff;
  localparam logic [11:0] MAX_PAGES = 12'h800;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } xfer_state_type;
endpackage : page_addr_pkg

// File: design/channel_decode.sv
// turns width code and bank select into a sixteen-channel enable mask
module channel_decode
  import page_addr_pkg::*;
(
  // selection
  input wire logic [3:0] width_code_i,
  input wire logic [3:0] bank_i,
  // result
  output logic [15:0] chan_en_o,
  output logic [9:0] page_bytes_o
);
  // one generate loop per channel compares the channel's group index
  for (genvar ch = 0; ch < 16; ch++) begin : g_chan
    localparam logic [3:0] CH = 4'(ch);
    always_comb begin
      case (width_code_i)
        WIDTH_X1: chan_en_o[ch] = (CH == bank_i);
        WIDTH_X2: chan_en_o[ch] = ({1'b0, CH[3:1]} == bank_i);
        WIDTH_X4: chan_en_o[ch] = ({2'b00, CH[3:2]} == bank_i);
        WIDTH_X8: chan_en_o[ch] = ({3'b000, CH[3]} == bank_i);
        WIDTH_X16: chan_en_o[ch] = 1'b1;
        default: chan_en_o[ch] = 1'b0; // illegal code selects nothing
      endcase
    end
  end

  // page size tracks channel width
  always_comb begin
    case (width_code_i)
      WIDTH_X1: page_bytes_o = PAGE_BYTES_X1;
      WIDTH_X2: page_bytes_o = PAGE_BYTES_X2;
      WIDTH_X4: page_bytes_o = PAGE_BYTES_X4;
      WIDTH_X8: page_bytes_o = PAGE_BYTES_X8;
      WIDTH_X16: page_bytes_o = PAGE_BYTES_X16;
      default: page_bytes_o = 10'h000;
    endcase
  end
endmodule : channel_decode

// File: design/bubble_page_address_logic.sv
module bubble_page_address_logic
  import page_addr_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // parametric register port
  input wire logic ptr_wr_i,
  input wire logic [3:0] ptr_data_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic [3:0] register_pointer_o,
  // transfer control
  input wire logic start_i,
  input wire logic page_done_i,
  output logic busy_o,
  output logic done_o,
  // addressing results
  output logic [10:0] page_addr_o,
  output logic [3:0] module_bank_select_o,
  output logic [15:0] chan_en_o,
  output logic [9:0] page_bytes_o,
  output logic [11:0] pages_left_o
);
  // reset release through two flops
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  logic rstn;
  assign rstn = rst_sync2_reg;

  // register state and next values, one group each
  logic [15:0] transfer_page_count_reg;
  logic [15:0] transfer_page_count_next;
  logic [15:0] start_page_address_reg;
  logic [15:0] start_page_address_next;
  logic [3:0] register_pointer_reg;
  logic [3:0] register_pointer_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [11:0] pages_left_reg;
  logic [11:0] pages_left_next;
  xfer_state_type state_reg;
  xfer_state_type state_next;
  logic [15:0] chan_en_reg;
  logic [15:0] chan_en_next;
  logic [9:0] page_bytes_reg;
  logic [9:0] page_bytes_next;

  // field views of the two working registers and the qualified strobes
  logic [PAGE_BITS-1:0] count_field;
  logic [PAGE_BITS-1:0] page_field;
  logic [BANK_BITS-1:0] bank_field;
  logic data_access;
  logic host_write_ok;
  logic page_step;
  assign count_field = transfer_page_count_reg[PAGE_BITS-1:0];
  assign page_field = start_page_address_reg[PAGE_BITS-1:0];
  assign bank_field = start_page_address_reg[BANK_LSB+BANK_BITS-1:BANK_LSB];
  // a data byte only counts when no pointer load shares the cycle
  assign data_access = !ptr_wr_i && (data_wr_i || data_rd_i);
  // busy writes dropped so the working counters stay coherent
  assign host_write_ok = !ptr_wr_i && data_wr_i && (state_reg != ST_RUN);
  // a page strobe outside a transfer is ignored
  assign page_step = (state_reg == ST_RUN) && page_done_i;

  // pointer and read byte group
  always_comb begin
    register_pointer_next = register_pointer_reg;
    data_next = data_reg;
    if (ptr_wr_i) begin
      register_pointer_next = ptr_data_i;
    end else if (data_access) begin
      // step, roll top address byte to fifo, then park on fifo
      if (register_pointer_reg == PTR_ADDR_HI) begin
        register_pointer_next = PTR_FIFO;
      end else if (register_pointer_reg != PTR_FIFO) begin
        register_pointer_next = register_pointer_reg + 4'h1;
      end
    end
    // write-only and unmodelled registers read as zero
    if (!ptr_wr_i && data_rd_i) begin
      case (register_pointer_reg)
        PTR_ADDR_LO: data_next = start_page_address_reg[7:0];
        PTR_ADDR_HI: data_next = start_page_address_reg[15:8];
        default: data_next = 8'h00;
      endcase
    end
  end

  // pointer and read byte registers
  always_ff @(posedge core_clk_i or negedge rstn) begin
    if (!rstn) begin
      register_pointer_reg <= PTR_RESET;
      data_reg <= DATA_RESET;
    end else begin
      register_pointer_reg <= register_pointer_next;
      data_reg <= data_next;
    end
  end

  // working registers: host bytes while idle, page counting while busy
  always_comb begin
    transfer_page_count_next = transfer_page_count_reg;
    start_page_address_next = start_page_address_reg;
    if (host_write_ok) begin
      case (register_pointer_reg)
        // low and high halves of the page count
        PTR_COUNT_LO: transfer_page_count_next[7:0] = data_i;
        PTR_COUNT_HI: transfer_page_count_next[15:8] = data_i;
        // spare top bit kept at zero
        PTR_ADDR_LO: start_page_address_next[7:0] = data_i;
        PTR_ADDR_HI: start_page_address_next[15:8] = {1'b0, data_i[6:0]};
        default: ;
      endcase
    end
    if (page_step) begin
      // count down, address up; the width field is left alone
      transfer_page_count_next[PAGE_BITS-1:0] = count_field - 11'h001;
      start_page_address_next[PAGE_BITS-1:0] = page_field + 11'h001;
      // wrap carries into the bank select
      if (page_field == LAST_PAGE) begin
        start_page_address_next[BANK_LSB+BANK_BITS-1:BANK_LSB] = bank_field + 4'h1;
      end
    end
  end

  // working registers
  always_ff @(posedge core_clk_i or negedge rstn) begin
    if (!rstn) begin
      transfer_page_count_reg <= COUNT_RESET;
      start_page_address_reg <= ADDR_RESET;
    end else begin
      transfer_page_count_reg <= transfer_page_count_next;
      start_page_address_reg <= start_page_address_next;
    end
  end

  // transfer sequencer and pages still to move
  always_comb begin
    state_next = state_reg;
    pages_left_next = pages_left_reg;
    case (state_reg)
      ST_IDLE, ST_DONE: begin
        if (start_i) begin
          // eleven-bit count, zero loads the full 2048
          if (count_field == 11'h000) begin
            pages_left_next = MAX_PAGES;
          end else begin
            pages_left_next = {1'b0, count_field};
          end
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (page_done_i) begin
          pages_left_next = pages_left_reg - 12'h001;
          // last requested page ends the transfer
          if (pages_left_reg == 12'h001) begin
            state_next = ST_DONE;
          end
        end
      end
      default: begin
        // unused code point falls back to idle
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk_i or negedge rstn) begin
    if (!rstn) begin
      pages_left_reg <= PAGES_LEFT_RESET;
      state_reg <= ST_IDLE;
    end else begin
      pages_left_reg <= pages_left_next;
      state_reg <= state_next;
    end
  end

  // decode of the next fields, so mask and size flop with them
  channel_decode u_channel_decode (
    .width_code_i(transfer_page_count_next[WIDTH_LSB+3:WIDTH_LSB]),
    .bank_i(start_page_address_next[BANK_LSB+BANK_BITS-1:BANK_LSB]),
    .chan_en_o(chan_en_next),
    .page_bytes_o(page_bytes_next)
  );

  // mask and size registered so the channel pins never glitch while a byte lands
  always_ff @(posedge core_clk_i or negedge rstn) begin
    if (!rstn) begin
      chan_en_reg <= CHAN_EN_RESET;
      page_bytes_reg <= PAGE_BYTES_RESET;
    end else begin
      chan_en_reg <= chan_en_next;
      page_bytes_reg <= page_bytes_next;
    end
  end

  // outputs straight from state
  assign data_o = data_reg;
  assign register_pointer_o = register_pointer_reg;
  assign busy_o = (state_reg == ST_RUN);
  assign done_o = (state_reg == ST_DONE);
  assign page_addr_o = page_field;
  assign module_bank_select_o = bank_field;
  assign chan_en_o = chan_en_reg;
  assign page_bytes_o = page_bytes_reg;
  assign pages_left_o = pages_left_reg;
endmodule : bubble_page_address_logic

// File: test/page_addr_monitor.sv
module page_addr_monitor (
  // watched ports
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ptr_wr_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic start_i,
  input wire logic page_done_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [3:0] register_pointer_o,
  input wire logic [10:0] page_addr_o,
  input wire logic [3:0] module_bank_select_o,
  input wire logic [15:0] chan_en_o,
  input wire logic [9:0] page_bytes_o,
  input wire logic [11:0] pages_left_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // a counted page: only while busy
  wire logic step = busy_o && page_done_i;
  wire logic acc = (data_wr_i || data_rd_i) && !ptr_wr_i;
  property p_start;
    start_i && !busy_o |=> busy_o && !done_o;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_page;
    step && page_addr_o != 11'h7ff |=> page_addr_o == $past(page_addr_o) + 11'h1;
  endproperty
  a_page: assert property (p_page) else $error("page not bumped");
  property p_wrap;
    step && page_addr_o == 11'h7ff
      |=> page_addr_o == 11'h0 && module_bank_select_o == $past(module_bank_select_o) + 4'h1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad page wrap");
  property p_left;
    step && pages_left_o > 12'h1 |=> busy_o && pages_left_o == $past(pages_left_o) - 12'h1;
  endproperty
  a_left: assert property (p_left) else $error("count not dropped");
  property p_end;
    step && pages_left_o == 12'h1 |=> !busy_o && done_o;
  endproperty
  a_end: assert property (p_end) else $error("transfer did not end");
  property p_idle;
    !busy_o && page_done_i && !data_wr_i |=> $stable(page_addr_o);
  endproperty
  a_idle: assert property (p_idle) else $error("idle page moved");
  property p_busy_wr;
    busy_o && data_wr_i && !page_done_i
      |=> $stable(page_addr_o) && $stable(module_bank_select_o);
  endproperty
  a_busy_wr: assert property (p_busy_wr) else $error("busy write landed");
  property p_roll;
    acc && register_pointer_o == 4'hf |=> register_pointer_o == 4'h0;
  endproperty
  a_roll: assert property (p_roll) else $error("pointer no roll");
  property p_inc;
    acc && register_pointer_o inside {[4'hb:4'he]}
      |=> register_pointer_o == $past(register_pointer_o) + 4'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer no step");
  property p_full;
    page_bytes_o == 10'h200 |-> chan_en_o == 16'hffff;
  endproperty
  a_full: assert property (p_full) else $error("full width mask");
endmodule : page_addr_monitor

bind bubble_page_address_logic page_addr_monitor u_page_addr_monitor (.core_clk_i, .rstn_i,
  .ptr_wr_i, .data_wr_i, .data_rd_i, .start_i, .page_done_i, .busy_o, .done_o,
  .register_pointer_o, .page_addr_o, .module_bank_select_o, .chan_en_o, .page_bytes_o,
  .pages_left_o);

// File: test/host_model.sv
module host_model (
  // clock
  input wire logic core_clk_i,
  // register port drive
  output logic ptr_wr_o,
  output logic [3:0] ptr_data_o,
  output logic data_wr_o,
  output logic data_rd_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet port at time zero
  initial {ptr_wr_o, data_wr_o, data_rd_o, ptr_data_o, data_o} = 15'h0;
  task automatic sel(input logic [3:0] p);
    @(negedge core_clk_i);
    ptr_wr_o = 1'b1;
    ptr_data_o = p;
    @(negedge core_clk_i);
    ptr_wr_o = 1'b0;
  endtask : sel
  // used while idle and while busy; released bus shows the inverse, not a stale byte
  task automatic wb(input logic [7:0] d);
    @(negedge core_clk_i);
    data_wr_o = 1'b1;
    data_o = d;
    @(negedge core_clk_i);
    data_wr_o = 1'b0;
    data_o = ~d;
  endtask : wb
  // one read strobe
  task automatic rb;
    @(negedge core_clk_i);
    data_rd_o = 1'b1;
    @(negedge core_clk_i);
    data_rd_o = 1'b0;
  endtask : rb
endmodule : host_model

// File: test/bubble_page_address_logic_bench.sv
module bubble_page_address_logic_bench;
  import page_addr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // bench signals
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic start_i = 1'b0;
  logic page_done_i = 1'b0;
  logic ptr_wr_i, data_wr_i, data_rd_i, busy_o, done_o;
  logic [3:0] ptr_data_i, register_pointer_o, module_bank_select_o;
  logic [7:0] data_i, data_o;
  logic [10:0] page_addr_o;
  logic [15:0] chan_en_o;
  logic [9:0] page_bytes_o;
  logic [11:0] pages_left_o;
  int n_mismatch = 0;
  int comparisons = 0;
  always #20 core_clk_i = ~core_clk_i;
  host_model u_host_model (.core_clk_i, .ptr_wr_o(ptr_wr_i), .ptr_data_o(ptr_data_i),
    .data_wr_o(data_wr_i), .data_rd_o(data_rd_i), .data_o(data_i));
  bubble_page_address_logic u_bubble_page_address_logic (.core_clk_i, .rstn_i, .ptr_wr_i,
    .ptr_data_i, .data_wr_i, .data_rd_i, .data_i, .data_o, .register_pointer_o, .start_i,
    .page_done_i, .busy_o, .done_o, .page_addr_o, .module_bank_select_o, .chan_en_o,
    .page_bytes_o, .pages_left_o);
  // compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge core_clk_i);
    s = 1'b1;
    @(negedge core_clk_i);
    s = 1'b0;
  endtask : pulse
  // every width code on bank 0
  task automatic t_width;
    logic [3:0] code [5] = '{WIDTH_X1, WIDTH_X2, WIDTH_X4, WIDTH_X8, WIDTH_X16};
    for (int i = 0; i < 5; i++) begin
      u_host_model.sel(PTR_COUNT_HI);
      u_host_model.wb({code[i], 4'h0});
      chk(16'(page_bytes_o), 16'h20 << i);
      chk(chan_en_o, (16'h1 << (1 << i)) - 16'h1);
    end
    $display("test width done");
  endtask : t_width
  // auto sequence load, then three pages across the bank wrap
  task automatic t_wrap;
    u_host_model.sel(PTR_COUNT_LO);
    u_host_model.wb(8'h03);
    u_host_model.wb(8'h40);
    u_host_model.wb(8'h00);
    u_host_model.wb(8'hfe);
    u_host_model.wb(8'h87);
    chk(16'(register_pointer_o), 16'h0000);
    chk(16'({module_bank_select_o, page_addr_o}), 16'h07fe);
    u_host_model.sel(PTR_ADDR_HI);
    u_host_model.rb();
    chk(16'(data_o), 16'h0007);
    pulse(start_i);
    chk(16'({busy_o, pages_left_o}), 16'h1003);
    pulse(page_done_i);
    pulse(page_done_i);
    chk(16'({module_bank_select_o, page_addr_o}), 16'h0800);
    chk(chan_en_o, 16'hff00);
    pulse(page_done_i);
    chk(16'({busy_o, done_o, pages_left_o}), 16'h1000);
    // a page strobe with no transfer running must leave the address alone
    pulse(page_done_i);
    chk(16'({module_bank_select_o, page_addr_o}), 16'h0801);
    $display("test wrap done");
  endtask : t_wrap
  // zero count is a full run of 2048 pages
  task automatic t_zero;
    u_host_model.sel(PTR_COUNT_LO);
    for (int i = 0; i < 5; i++) u_host_model.wb(i == 1 ? 8'h80 : 8'h00);
    pulse(start_i);
    chk(chan_en_o, 16'hffff);
    chk(16'(pages_left_o), 16'h0800);
    // a byte aimed at the address while busy is dropped, the pointer still steps
    u_host_model.sel(PTR_ADDR_LO);
    u_host_model.wb(8'h55);
    chk(16'(register_pointer_o), 16'h000f);
    chk(16'(page_addr_o), 16'h0000);
    repeat (2048) pulse(page_done_i);
    chk(16'({module_bank_select_o, page_addr_o}), 16'h0800);
    chk(16'({busy_o, done_o}), 16'h0001);
    $display("test zero done");
  endtask : t_zero
  // reset in mid-transfer, then a one-page run to show the logic is live again
  task automatic t_reset;
    u_host_model.sel(PTR_COUNT_LO);
    u_host_model.wb(8'h05);
    pulse(start_i);
    pulse(page_done_i);
    @(negedge core_clk_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk(16'({busy_o, done_o, pages_left_o}), 16'h0000);
    rstn_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk(16'({module_bank_select_o, page_addr_o}), 16'(ADDR_RESET[14:0]));
    chk(16'({register_pointer_o, data_o}), 16'({PTR_RESET, DATA_RESET}));
    chk(chan_en_o, 16'h0001);
    chk(16'(page_bytes_o), 16'(PAGE_BYTES_X1));
    u_host_model.sel(PTR_COUNT_LO);
    u_host_model.wb(8'h01);
    pulse(start_i);
    pulse(page_done_i);
    chk(16'({busy_o, done_o, pages_left_o}), 16'h1000);
    chk(16'(page_addr_o), 16'h0001);
    $display("test reset done");
  endtask : t_reset
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // reset, tests and hang guard
  initial begin
    repeat (5) @(negedge core_clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    t_width();
    t_wrap();
    t_zero();
    t_reset();
    close_out();
  end
  initial begin
    #1000000;
    n_mismatch++;
    close_out();
  end
endmodule : bubble_page_address_logic_bench
